// ### hw/fvadc_params.svh
// constants shared by both ends of the flash video adc port
`ifndef FVADC_PARAMS_SVH
`define FVADC_PARAMS_SVH
`define FVADC_CODE_W 8
`define FVADC_CODE_MIN 8'h00
`define FVADC_CODE_MAX 8'hFF
`define FVADC_SAMPLE_W 9
`define FVADC_INIT_NULL_CYC 1000
`define FVADC_NULL_GAP_US 150
`define FVADC_CLK_MHZ 250
`define FVADC_NULL_GAP_CYC (`FVADC_NULL_GAP_US * `FVADC_CLK_MHZ)
`define FVADC_NULL_LEN 16
`endif

// ### hw/fvadc_pkg.sv
// types shared by both ends of the flash video adc port
`default_nettype none
`include "fvadc_params.svh"
package fvadc_pkg;
  typedef logic [`FVADC_CODE_W-1:0] fvadc_code_t;
  typedef enum logic [1:0] {FVADC_RUN, FVADC_NULL} fvadc_mode_e;
endpackage : fvadc_pkg
`default_nettype wire

// ### hw/fvadc_if.sv
// wires between converter and capture logic
`default_nettype none
interface fvadc_if;
  logic conv_clk;
  logic null_req;
  logic clamp;
  logic drive_en_n;
  logic [7:0] data_o;
  logic data_oe;
  logic [7:0] data_bus;
  logic overflow;
  // floating data pins read as zero; no three-state inside the fabric
  assign data_bus = data_oe ? data_o : 8'h00;
  modport conv (input conv_clk, null_req, clamp, drive_en_n,
    output data_o, data_oe, overflow);
  modport cap (output conv_clk, null_req, clamp, drive_en_n,
    input data_bus, overflow);
endinterface : fvadc_if
`default_nettype wire

// ### hw/fvadc_conv.sv
// converter end: digital model of the flash converter's output port
`default_nettype none
`include "fvadc_params.svh"
module fvadc_conv (
  // link
  fvadc_if.conv lnk,
  // analog stand-in: sample value, above-range flag and clamp level
  input wire logic [`FVADC_CODE_W-1:0] ain_code,
  input wire logic ain_over,
  input wire logic [`FVADC_CODE_W-1:0] clamp_code,
  // clamp state seen by the analog front end
  output logic clamp_act
);
  import fvadc_pkg::*;
  logic [`FVADC_SAMPLE_W-1:0] smp;
  logic [`FVADC_SAMPLE_W-1:0] stage;
  logic [`FVADC_SAMPLE_W-1:0] outr;
  logic [`FVADC_SAMPLE_W-1:0] next_smp;
  // no reset pin: contents are undefined until first samples arrive
  // clamp overrides the input without a clock
  assign clamp_act = lnk.clamp;
  assign next_smp = clamp_act ? {1'b0, clamp_code} :
                    ain_over ? {1'b1, `FVADC_CODE_MAX} :
                    {1'b0, ain_code};
  always_ff @(negedge lnk.conv_clk) begin
    smp <= next_smp;
  end
  // two rising edges from sample to pins; nulling stalls both stages
  always_ff @(posedge lnk.conv_clk) begin
    if (!lnk.null_req) begin
      stage <= smp;
      outr <= stage;
    end
  end
  assign lnk.data_o = outr[`FVADC_CODE_W-1:0];
  assign lnk.overflow = outr[`FVADC_CODE_W];
  assign lnk.data_oe = !lnk.drive_en_n;
endmodule : fvadc_conv
`default_nettype wire

// ### hw/fvadc_cap.sv
// capture end: drives clock and controls, collects samples
`default_nettype none
`include "fvadc_params.svh"
module fvadc_cap #(
  parameter int INIT_NULL = `FVADC_INIT_NULL_CYC,
  parameter int NULL_GAP = `FVADC_NULL_GAP_CYC,
  parameter int NULL_LEN = `FVADC_NULL_LEN
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // link
  fvadc_if.cap lnk,
  // user controls
  input wire logic ac_coupled,
  input wire logic blank,
  // sample stream out
  output logic [`FVADC_SAMPLE_W-1:0] smp_data,
  output logic smp_valid,
  input wire logic smp_ready,
  output logic ready_ok
);
  import fvadc_pkg::*;
  initial begin
    if (INIT_NULL < 1 || NULL_LEN < 1 || NULL_GAP <= NULL_LEN)
      $error("fvadc_cap: bad timing parameters");
  end
  fvadc_mode_e st;
  logic [31:0] cnt;
  logic [31:0] gap;
  logic [1:0] clkdiv;
  logic rise;
  logic nul;
  logic [2:0] lat;
  logic [`FVADC_SAMPLE_W-1:0] s1;
  logic [`FVADC_SAMPLE_W-1:0] s2;
  logic [`FVADC_SAMPLE_W-1:0] b1;
  logic [1:0] cnt_buf;
  logic blank_q;
  // conversion clock is sys_clk / 4, made here so no second domain
  assign lnk.conv_clk = clkdiv[1];
  assign rise = (clkdiv == 2'h1);
  assign lnk.null_req = nul;
  assign lnk.clamp = ac_coupled & blank;
  // data pins stay released until power-up nulling is done
  assign lnk.drive_en_n = !ready_ok;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) clkdiv <= 2'h0;
    else clkdiv <= clkdiv + 2'h1;
  end
  // null after reset, then at each blank start seen while running, or when gap runs out
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= FVADC_NULL;
      cnt <= 32'h0;
      gap <= 32'h0;
      nul <= 1'b1;
      ready_ok <= 1'b0;
      blank_q <= 1'b0;
    end else begin
      blank_q <= blank;
      unique case (st)
        FVADC_NULL: begin
          if (rise) cnt <= cnt + 32'h1;
          if (rise && cnt + 32'h1 >= (ready_ok ? NULL_LEN : INIT_NULL)) begin
            st <= FVADC_RUN;
            nul <= 1'b0;
            ready_ok <= 1'b1;
            gap <= 32'h0;
          end
        end
        FVADC_RUN: begin
          gap <= gap + 32'h1;
          if ((blank && !blank_q) || gap >= NULL_GAP - NULL_LEN) begin
            st <= FVADC_NULL;
            nul <= 1'b1;
            cnt <= 32'h0;
          end
        end
        default: st <= FVADC_NULL;
      endcase
    end
  end
  // pins are outside this clock's sampling: two flops before use
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      lat <= 3'h0;
    end else begin
      s1 <= {lnk.overflow, lnk.data_bus};
      s2 <= s1;
      // pins move at the rise, then two sync flops: word is in s2 2 later
      lat <= {lat[1:0], rise & !nul};
    end
  end
  // two-entry buffer; a word arriving while full is dropped unless a word is popped in the same cycle
  wire take = lat[2] & ready_ok & !nul;
  wire pop = smp_valid & smp_ready;
  wire acc = take & ((cnt_buf != 2'h2) | pop);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_buf <= 2'h0;
      b1 <= '0;
      smp_valid <= 1'b0;
      smp_data <= '0;
    end else begin
      cnt_buf <= cnt_buf + {1'b0, acc} - {1'b0, pop};
      unique case (cnt_buf)
        2'h0: begin
          if (acc) begin
            smp_data <= s2;
            smp_valid <= 1'b1;
          end
        end
        2'h1: begin
          if (pop && acc) smp_data <= s2;
          else if (pop) smp_valid <= 1'b0;
          else if (acc) b1 <= s2;
        end
        2'h2: begin
          if (pop) smp_data <= b1;
          if (acc) b1 <= s2;
        end
        default: cnt_buf <= 2'h0;
      endcase
    end
  end
endmodule : fvadc_cap
`default_nettype wire

// ### dv/fvadc_props.sv
// checker on the link between the two ends
`default_nettype none
module fvadc_props (
  // clock and reset
  input wire logic conv_clk,
  input wire logic rstn,
  // link
  input wire logic null_req,
  input wire logic drive_en_n,
  input wire logic [7:0] data_o,
  input wire logic data_oe,
  input wire logic overflow
);
  default clocking @(posedge conv_clk); endclocking
  default disable iff (!rstn);
  // margin over the gap of 64 plus one burst
  localparam int GAP = 70;
  sequence s_null4;
    null_req[*4];
  endsequence
  a_init_null: assert property ($rose(rstn) |-> s_null4 ##1 s_null4)
    else $error("power-up nulling too short");
  a_null_burst: assert property ($rose(null_req) |-> s_null4)
    else $error("nulling burst too short");
  a_null_gap: assert property ($fell(null_req) |-> ##[1:GAP] null_req)
    else $error("nulling gap too long");
  a_code_hold: assert property ($changed(data_o) |-> !$past(null_req))
    else $error("code moved while nulling");
  a_ovf_hold: assert property ($changed(overflow) |-> !$past(null_req))
    else $error("overflow moved while nulling");
  a_ovf_max: assert property (overflow |-> data_o == 8'hFF)
    else $error("overflow without full code");
  a_oe_on: assert property (!drive_en_n |-> data_oe)
    else $error("data not driven");
  a_oe_off: assert property (drive_en_n |-> !data_oe)
    else $error("data driven while disabled");
endmodule : fvadc_props
`default_nettype wire

// ### dv/fvadc_bench.sv
// bench: both ends joined, samples checked at the capture side
`default_nettype none
module fvadc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rstn, ac_coupled, blank, smp_ready, ain_over, clamp_act;
  logic smp_valid, ready_ok;
  logic [7:0] ain_code, clamp_code;
  logic [8:0] smp_data;
  int errors, checks;
  fvadc_if lnk_if ();
  fvadc_conv fvadc_conv_inst (.lnk(lnk_if), .ain_code(ain_code),
    .ain_over(ain_over), .clamp_code(clamp_code), .clamp_act(clamp_act));
  fvadc_cap #(.INIT_NULL(8), .NULL_GAP(64), .NULL_LEN(4)) fvadc_cap_inst (
    .sys_clk(sys_clk), .rstn(rstn), .lnk(lnk_if), .ac_coupled(ac_coupled),
    .blank(blank), .smp_data(smp_data), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .ready_ok(ready_ok));
  fvadc_props props_inst (.conv_clk(lnk_if.conv_clk), .rstn(rstn),
    .null_req(lnk_if.null_req), .drive_en_n(lnk_if.drive_en_n),
    .data_o(lnk_if.data_o), .data_oe(lnk_if.data_oe),
    .overflow(lnk_if.overflow));
  function automatic logic [8:0] exp_word(logic [7:0] c, logic o, logic k);
    return k ? {1'b0, clamp_code} : {o, o ? 8'hFF : c};
  endfunction : exp_word
  task automatic check(logic [8:0] seen, logic [8:0] want);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // random stalls first, then a flush so the next word is fresh
  task automatic put(logic [7:0] c, logic o, logic k);
    int n = 0;
    ain_code = c;
    ain_over = o;
    ac_coupled = k;
    blank = k;
    repeat (24) begin
      @(negedge sys_clk);
      smp_ready = 1'($urandom);
    end
    smp_ready = 1'b1;
    repeat (32) @(negedge sys_clk);
    while (smp_valid !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 400) begin
      errors++;
      end_sim();
    end else begin
      check(smp_data, exp_word(c, o, k));
      check(9'(clamp_act), 9'(k));
    end
  endtask : put
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    int n = 0;
    rstn = 1'b0;
    ac_coupled = 1'b0;
    blank = 1'b0;
    smp_ready = 1'b0;
    ain_code = 8'h00;
    ain_over = 1'b0;
    errors = 0;
    checks = 0;
    void'($urandom(74));
    clamp_code = 8'($urandom);
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    check(9'(ready_ok), 9'h000);
    // eight conversion clocks of nulling are four system clocks each
    while (ready_ok !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    check(9'(n >= 28 && n < 400), 9'h001);
    put(8'h00, 1'b0, 1'b0);
    put(8'hFF, 1'b0, 1'b0);
    put(8'h7F, 1'b1, 1'b0);
    put(8'h80, 1'b0, 1'b1);
    repeat (12) put(8'($urandom), 1'($urandom), 1'($urandom));
    end_sim();
  end
endmodule : fvadc_bench
`default_nettype wire
